// >>> inc/pai_pkg.sv
`default_nettype none
package pai_pkg;
  localparam int RES_W = 12;
  localparam int AIN_W = 16;
  localparam int REF_W = 13;
  localparam int DIFF_W = AIN_W + 1;
  localparam int AMP_W = AIN_W + 2;
  localparam int SCL_W = 32;
  localparam int FS_SHIFT = 12;
  localparam int SYNC_W = 1 + 1 + 2 + AIN_W + AIN_W + REF_W;
  localparam int SYNC_CLK_BIT = 0;
  localparam int SYNC_GAIN_BIT = 1;
  localparam int SYNC_REF_LSB = 2;
  localparam int SYNC_POS_LSB = 4;
  localparam int SYNC_NEG_LSB = SYNC_POS_LSB + AIN_W;
  localparam int SYNC_EXT_LSB = SYNC_NEG_LSB + AIN_W;
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_PERIOD_NS = 20;
  localparam int CONV_TIME_NS = 70;
  localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] CONV_LOAD = CNT_W'(CONV_CYC - 1);
  localparam int IDLE_TIME_US = 500;
  localparam int IDLE_CYC = IDLE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam logic [REF_W-1:0] VREF_HI_MV = 13'h1000;
  localparam logic [REF_W-1:0] VREF_LO_MV = 13'h0800;
  localparam logic [REF_W-1:0] VREF_ONE = 13'h0001;
  localparam logic [REF_W-1:0] VREF_ZERO = 13'h0000;
  localparam logic [RES_W-1:0] CODE_MAX = 12'h7ff;
  localparam logic [RES_W-1:0] CODE_MIN = 12'h800;
  localparam logic [RES_W-1:0] CODE_RST = 12'h000;
  localparam logic signed [SCL_W-1:0] SCL_MAX = 32'sh0000_07ff;
  localparam logic signed [SCL_W-1:0] SCL_MIN = 32'shffff_f800;
  typedef enum logic [1:0] {
    PAI_REF_GND    = 2'h0,
    PAI_REF_PIN    = 2'h1,
    PAI_REF_SUPPLY = 2'h2
  } pai_ref_t;
  typedef enum logic {
    PAI_IDLE = 1'b0,
    PAI_CONV = 1'b1
  } pai_conv_t;
endpackage : pai_pkg
`default_nettype wire

// >>> logic/pai_adc_core.sv
// Contract
// - Each rising sample clock edge taken while the FIFO has room starts a conversion and samples both analog inputs at once.
// - A result reaches the output after two further starts plus the 70 ns conversion time.
// - Conversions overlap in the pipeline and a result is ready for the third edge after sampling.
// - Results are 12-bit two's complement words with bit 11 most significant.
// - The out-of-range flag is high exactly when the word is the most positive or most negative code.
// - After 500 us without a sample edge an internal timer pulses refresh_pulse and leaves the pipeline contents as they are.
// - Gain select high gives unity gain and range of half the reference, low gives gain two.
// - Reference mode selects internal 4.096 V, internal 2.048 V, or an external reference.
// - A started conversion runs to completion and a further edge does not abort it.
`timescale 1ns/1ps
`default_nettype none

module pai_fifo #(
  parameter int W     = 12,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem_ff [DEPTH];
  logic [AW:0]   wr_ff;
  logic [AW:0]   rd_ff;
  wire           full_w  = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
  wire           empty_w = (wr_ff == rd_ff);
  wire           wr_en_w = in_valid && !full_w;
  wire           rd_en_w = out_ready && !empty_w;
  wire [AW:0]    one_w   = (AW+1)'(1);

  assign in_ready  = !full_w;
  assign out_valid = !empty_w;
  assign out_data  = mem_ff[rd_ff[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (wr_en_w)
    begin
      mem_ff[wr_ff[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
    end
    else
    begin
      if (wr_en_w)
        wr_ff <= wr_ff + one_w;
      if (rd_en_w)
        rd_ff <= rd_ff + one_w;
    end
  end
endmodule : pai_fifo

module pai_adc_core #(
  parameter int IDLE_CYCLES = pai_pkg::IDLE_CYC,
  parameter int FIFO_DEPTH  = pai_pkg::FIFO_DEPTH
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       sample_clk,
  input  wire logic [pai_pkg::AIN_W-1:0]  positive_analog_input,
  input  wire logic [pai_pkg::AIN_W-1:0]  negative_analog_input,
  input  wire logic                       gain_select,
  input  wire logic [1:0]                 reference_mode,
  input  wire logic [pai_pkg::REF_W-1:0]  external_reference_mv,
  output logic [pai_pkg::RES_W-1:0]       result_word,
  output logic                            out_of_range_flag,
  output logic                            result_valid,
  output logic                            refresh_pulse
);
  localparam int SW     = pai_pkg::SYNC_W;
  localparam int RW     = pai_pkg::RES_W;
  localparam int IDLE_W = $clog2(IDLE_CYCLES + 1);
  localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(IDLE_CYCLES - 1);
  localparam logic [IDLE_W-1:0] IDLE_ONE  = IDLE_W'(1);

  logic [1:0]    rst_sync_ff;
  wire           rst_sync_n = rst_sync_ff[1];

  // Reset is asserted at once and released two clock edges later.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end

  wire [SW-1:0]  pin_w = {external_reference_mv, negative_analog_input,
                          positive_analog_input, reference_mode, gain_select, sample_clk};
  logic [SW-1:0] s1_ff;
  logic [SW-1:0] s2_ff;
  logic [SW-1:0] s3_ff;
  logic [SW-1:0] q_ff;

  // Every pin passes three flops; its level is taken once stages two and three agree.
  for (genvar i = 0; i < SW; i++)
  begin : g_sync
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
      if (!rst_sync_n)
      begin
        s1_ff[i] <= 1'b0;
        s2_ff[i] <= 1'b0;
        s3_ff[i] <= 1'b0;
        q_ff[i]  <= 1'b0;
      end
      else
      begin
        s1_ff[i] <= pin_w[i];
        s2_ff[i] <= s1_ff[i];
        s3_ff[i] <= s2_ff[i];
        if (s2_ff[i] == s3_ff[i])
          q_ff[i] <= s3_ff[i];
      end
    end
  end

  wire           rise_w = s2_ff[pai_pkg::SYNC_CLK_BIT] && s3_ff[pai_pkg::SYNC_CLK_BIT]
                          && !q_ff[pai_pkg::SYNC_CLK_BIT];
  wire           gain_q = q_ff[pai_pkg::SYNC_GAIN_BIT];
  wire [1:0]     ref_q  = q_ff[pai_pkg::SYNC_REF_LSB +: 2];
  wire signed [pai_pkg::AIN_W-1:0] pos_q = q_ff[pai_pkg::SYNC_POS_LSB +: pai_pkg::AIN_W];
  wire signed [pai_pkg::AIN_W-1:0] neg_q = q_ff[pai_pkg::SYNC_NEG_LSB +: pai_pkg::AIN_W];
  wire [pai_pkg::REF_W-1:0] ext_q = q_ff[pai_pkg::SYNC_EXT_LSB +: pai_pkg::REF_W];

  wire signed [pai_pkg::DIFF_W-1:0] diff_w = pai_pkg::DIFF_W'(pos_q) - pai_pkg::DIFF_W'(neg_q);
  // Gain two doubles the difference, halving the usable input span.
  wire signed [pai_pkg::AMP_W-1:0] amp_w = gain_q ? pai_pkg::AMP_W'(diff_w)
                                                  : {diff_w, 1'b0};
  wire ref_gnd_w = (ref_q == pai_pkg::PAI_REF_GND);
  wire ref_pin_w = (ref_q == pai_pkg::PAI_REF_PIN);
  wire [pai_pkg::REF_W-1:0] vref_w = ref_gnd_w ? pai_pkg::VREF_HI_MV
                                   : ref_pin_w ? pai_pkg::VREF_LO_MV
                                   : ext_q;
  // A dead external reference would divide by zero, so it is treated as one millivolt.
  wire [pai_pkg::REF_W-1:0] vref_safe_w = (vref_w == pai_pkg::VREF_ZERO) ? pai_pkg::VREF_ONE
                                                                       : vref_w;
  wire signed [pai_pkg::SCL_W-1:0] num_w = pai_pkg::SCL_W'(amp_w) <<< pai_pkg::FS_SHIFT;
  wire signed [pai_pkg::SCL_W-1:0] den_w = $signed(pai_pkg::SCL_W'(vref_safe_w));
  wire signed [pai_pkg::SCL_W-1:0] scaled_w = num_w / den_w;
  wire [RW-1:0]  code_w = (scaled_w > pai_pkg::SCL_MAX) ? pai_pkg::CODE_MAX
                        : (scaled_w < pai_pkg::SCL_MIN) ? pai_pkg::CODE_MIN
                        : scaled_w[RW-1:0];

  logic [RW-1:0] stage0_ff;
  logic [RW-1:0] stage1_ff;
  logic [1:0]    vld_ff;
  logic          fifo_in_ready;
  logic          fifo_out_valid;
  logic [RW-1:0] fifo_out_data;
  wire           advance_w = rise_w && fifo_in_ready;
  wire           push_w    = advance_w && vld_ff[1];

  pai_pkg::pai_conv_t          state_ff;
  pai_pkg::pai_conv_t          nxt_state;
  logic [pai_pkg::CNT_W-1:0]   cnt_ff;
  logic [pai_pkg::CNT_W-1:0]   nxt_cnt;
  wire                         done_w = (state_ff == pai_pkg::PAI_CONV) && (cnt_ff == '0);
  wire                         pop_w  = done_w;
  wire [pai_pkg::CNT_W-1:0]    cnt_one = pai_pkg::CNT_W'(1);

  // A sample enters on its own edge and starts its final stage two edges later.
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      stage0_ff <= pai_pkg::CODE_RST;
      stage1_ff <= pai_pkg::CODE_RST;
      vld_ff    <= 2'h0;
    end
    else if (advance_w)
    begin
      stage0_ff <= code_w;
      stage1_ff <= stage0_ff;
      vld_ff    <= {vld_ff[0], 1'b1};
    end
  end

  pai_fifo #(
    .W     (RW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_sync_n),
    .in_valid  (push_w),
    .in_data   (stage1_ff),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (pop_w)
  );

  // Sample edges are not looked at here, so a running conversion always finishes.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      pai_pkg::PAI_IDLE:
      begin
        if (fifo_out_valid)
        begin
          nxt_state = pai_pkg::PAI_CONV;
          nxt_cnt   = pai_pkg::CONV_LOAD;
        end
      end
      pai_pkg::PAI_CONV:
      begin
        if (cnt_ff == '0)
          nxt_state = pai_pkg::PAI_IDLE;
        else
          nxt_cnt = cnt_ff - cnt_one;
      end
      default:
      begin
        nxt_state = pai_pkg::PAI_IDLE;
        nxt_cnt   = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state_ff <= pai_pkg::PAI_IDLE;
      cnt_ff   <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  wire flag_w = (fifo_out_data == pai_pkg::CODE_MAX) || (fifo_out_data == pai_pkg::CODE_MIN);

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      result_word       <= pai_pkg::CODE_RST;
      out_of_range_flag <= 1'b0;
      result_valid      <= 1'b0;
    end
    else
    begin
      result_valid <= done_w;
      if (done_w)
      begin
        result_word       <= fifo_out_data;
        out_of_range_flag <= flag_w;
      end
    end
  end

  logic [IDLE_W-1:0] idle_ff;
  wire               idle_end_w = (idle_ff == IDLE_LAST) && !rise_w;

  // The refresh strobe repeats every idle period while the sample clock stays still.
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      idle_ff       <= '0;
      refresh_pulse <= 1'b0;
    end
    else
    begin
      refresh_pulse <= idle_end_w;
      if (rise_w || idle_end_w)
        idle_ff <= '0;
      else
        idle_ff <= idle_ff + IDLE_ONE;
    end
  end

  property p_start;
    @(posedge clk) disable iff (!rst_sync_n)
    advance_w |=> (stage0_ff == $past(code_w)) && vld_ff[0];
  endproperty
  a_start: assert property (p_start) else $error("sample not taken on edge");

  property p_out_update;
    @(posedge clk) disable iff (!rst_sync_n)
    done_w |=> result_valid && (result_word == $past(fifo_out_data));
  endproperty
  a_out_update: assert property (p_out_update) else $error("result not updated");

  property p_conv_time;
    @(posedge clk) disable iff (!rst_sync_n)
    $rose(state_ff == pai_pkg::PAI_CONV) |-> (!done_w)[*3] ##1 done_w;
  endproperty
  a_conv_time: assert property (p_conv_time) else $error("conversion time wrong");

  property p_pipe;
    @(posedge clk) disable iff (!rst_sync_n)
    push_w |-> ##[1:60] result_valid;
  endproperty
  a_pipe: assert property (p_pipe) else $error("pipelined result never emerged");

  property p_saturate;
    @(posedge clk) disable iff (!rst_sync_n)
    (scaled_w > pai_pkg::SCL_MAX) |-> (code_w == pai_pkg::CODE_MAX);
  endproperty
  a_saturate: assert property (p_saturate) else $error("positive clip code wrong");

  property p_flag;
    @(posedge clk) disable iff (!rst_sync_n)
    out_of_range_flag == ((result_word == pai_pkg::CODE_MAX) ||
                          (result_word == pai_pkg::CODE_MIN));
  endproperty
  a_flag: assert property (p_flag) else $error("flag does not match word");

  property p_refresh;
    @(posedge clk) disable iff (!rst_sync_n)
    rise_w |=> !refresh_pulse && (idle_ff == '0);
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh despite sample edge");

  property p_unity;
    @(posedge clk) disable iff (!rst_sync_n)
    (gain_q && ref_gnd_w && (diff_w > -17'sh0800) && (diff_w < 17'sh0800))
      |-> (code_w == diff_w[RW-1:0]);
  endproperty
  a_unity: assert property (p_unity) else $error("unity gain code wrong");

  property p_lowref;
    @(posedge clk) disable iff (!rst_sync_n)
    (gain_q && ref_pin_w && (diff_w > -17'sh0400) && (diff_w < 17'sh0400))
      |-> (code_w == {diff_w[RW-2:0], 1'b0});
  endproperty
  a_lowref: assert property (p_lowref) else $error("low reference code wrong");

  property p_no_abort;
    @(posedge clk) disable iff (!rst_sync_n)
    (state_ff == pai_pkg::PAI_CONV && cnt_ff != '0 && rise_w)
      |=> (state_ff == pai_pkg::PAI_CONV) && (cnt_ff == $past(cnt_ff) - cnt_one);
  endproperty
  a_no_abort: assert property (p_no_abort) else $error("edge disturbed conversion");
endmodule : pai_adc_core
`default_nettype wire

// >>> tb/pai_cap_model.sv
`timescale 1ns/1ps
`default_nettype none
module pai_cap_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        run,
  input  wire logic [7:0]  half,
  input  wire logic [11:0] result_word,
  input  wire logic        out_of_range_flag,
  output logic             sample_clk,
  output logic [11:0]      cap_word,
  output logic             cap_flag
);
  logic [7:0] cnt_ff;

  // A stop only takes effect once the clock is low, so no level is cut short.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff     <= 8'h00;
      sample_clk <= 1'b0;
      cap_word   <= 12'h000;
      cap_flag   <= 1'b0;
    end
    else if (cnt_ff >= half - 8'h01)
    begin
      cnt_ff <= 8'h00;
      if (sample_clk || run)
        sample_clk <= ~sample_clk;
      if (!sample_clk && run)
      begin
        cap_word <= {~result_word[11], result_word[10:0]};
        cap_flag <= out_of_range_flag;
      end
    end
    else
      cnt_ff <= cnt_ff + 8'h01;
  end
endmodule : pai_cap_model
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic               clk;
  logic               rst_n;
  logic               run;
  logic [7:0]         half;
  logic               sample_clk;
  logic signed [15:0] pos;
  logic signed [15:0] neg;
  logic               gain;
  logic [1:0]         rmode;
  logic [12:0]        eref;
  logic [11:0]        word;
  logic               flag;
  logic               valid;
  logic               refresh;
  logic [11:0]        cap_word;
  logic               cap_flag;
  logic [31:0]        rng;
  logic               sc_prev;
  logic [12:0]        q[$];
  logic [12:0]        hist[$];
  logic [12:0]        exp_v;
  int                 errors, checks, n_edge, n_ref, n_dir, r0, n_res;
  logic signed [15:0] dir [6] = '{16'sh07ff, 16'sh07fe, 16'shf800, 16'shf801,
                                  16'sh0bb8, 16'shf448};

  pai_adc_core #(.IDLE_CYCLES(20), .FIFO_DEPTH(8)) dut (
    .clk(clk), .rst_n(rst_n), .sample_clk(sample_clk), .positive_analog_input(pos),
    .negative_analog_input(neg), .gain_select(gain), .reference_mode(rmode),
    .external_reference_mv(eref), .result_word(word), .out_of_range_flag(flag),
    .result_valid(valid), .refresh_pulse(refresh));
  pai_cap_model partner (
    .clk(clk), .rst_n(rst_n), .run(run), .half(half), .result_word(word),
    .out_of_range_flag(flag), .sample_clk(sample_clk), .cap_word(cap_word),
    .cap_flag(cap_flag));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  function automatic logic [12:0] model(input logic signed [15:0] p, input logic signed [15:0] m,
                                        input logic g, input logic [1:0] rm, input logic [12:0] e);
    longint d;
    longint v;
    d = (longint'(p) - longint'(m)) * (g ? 4096 : 8192);
    v = (rm == 2'h0) ? 4096 : (rm == 2'h1) ? 2048 : (e == 13'h0) ? 1 : longint'(e);
    d = d / v;
    if (d > 2047) d = 2047;
    if (d < -2048) d = -2048;
    return {d == 2047 || d == -2048, d[11:0]};
  endfunction : model

  task automatic check(input logic [12:0] seen, input logic [12:0] exp, input string msg);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic wait_edges(input int k);
    int t;
    t = n_edge + k;
    for (int i = 0; i < 5000 && n_edge < t; i++) @(posedge clk);
    @(negedge clk);
  endtask : wait_edges

  // Notes the expectation at each rise and moves the inputs after each fall.
  always @(negedge clk)
  begin
    if (sample_clk && !sc_prev)
    begin
      exp_v = model(pos, neg, gain, rmode, eref);
      q.push_back(exp_v);
      hist.push_back(exp_v);
      if (n_edge >= 3) check({cap_flag, cap_word}, hist[n_edge - 3] ^ 13'h0800, "capture");
      n_edge++;
    end
    if (!sample_clk && sc_prev)
    begin
      rng = lfsr(rng);
      pos = (n_dir < 6) ? dir[n_dir] : $signed(rng[15:0]) >>> rng[19:16];
      neg = (n_dir < 6) ? 16'sh0000 : 16'($signed(rng[31:24]));
      gain = (n_dir < 6) ? 1'b1 : rng[20];
      rmode = (n_dir < 6) ? 2'h0 : rng[22:21];
      eref = (rng[25:24] == 2'h0) ? 13'h0000 : rng[12:0];
      n_dir++;
    end
    sc_prev = sample_clk;
  end

  always @(negedge clk)
  begin
    if (refresh === 1'b1) n_ref++;
    if (valid === 1'b1)
    begin
      n_res++;
      check(13'(q.size()), 13'h3, "latency");
      if (q.size() > 0) check({flag, word}, q.pop_front(), "result");
    end
  end

  // Restarts with two samples held in the pipeline and counts what comes out.
  task automatic burst_test;
    int r1;
    int rr;
    r1 = n_res;
    rr = n_ref;
    run = 1'b1;
    wait_edges(8);
    run = 1'b0;
    repeat (40) @(negedge clk);
    check(13'(n_res - r1), 13'h0008, "burst results");
    check(13'(q.size()), 13'h0002, "burst pending");
    check(13'(valid), 13'h0000, "valid idle");
    check(13'(n_ref - rr > 0), 13'h0001, "refresh after stop");
    $display("test burst done");
  endtask : burst_test

  initial
  begin
    rst_n = 1'b0; run = 1'b0; half = 8'h06; pos = 16'sh0000; neg = 16'sh0000;
    gain = 1'b1; rmode = 2'h0; eref = 13'h1000;
    rng = 32'h54ed1142; sc_prev = 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    run = 1'b1;
    wait_edges(40);
    check(13'(n_ref), 13'h0000, "refresh while clocked");
    $display("test fast done");
    half = 8'h14;
    wait_edges(16);
    $display("test slow done");
    run = 1'b0;
    repeat (60) @(negedge clk);
    @(posedge clk) r0 = n_ref;
    repeat (200) @(posedge clk);
    check(13'(n_ref - r0 >= 8 && n_ref - r0 <= 11), 13'h0001, "refresh count");
    @(negedge clk);
    half = 8'h06;
    run = 1'b1;
    wait_edges(10);
    run = 1'b0;
    repeat (40) @(negedge clk);
    check(13'(q.size()), 13'h0002, "pending");
    $display("test refresh done");
    burst_test;
    summarize;
  end

  initial
  begin
    #100us;
    errors++;
    $display("BAD %0t watchdog expired", $time);
    summarize;
  end
endmodule : tb_top
`default_nettype wire
